//--- verilog/afr_core.sv
// Accumulator bank, flags, RAM pointer and measurement result map.
// Assumes the sequencer and converter run on ref_clk and issue one
// operation per cycle; converter data arrives already synchronous.
//
// Notes on behaviour
// RL1 - Working RAM has 127 words of 24 bits on its own address.
// RL2 - Word chosen by the pointer acts as fourth accumulator.
// RL3 - Changing the pointer never alters any RAM word.
// RL4 - Pointer changes only by load, increment or decrement commands, or by measurement end.
// RL5 - Three independent 24-bit accumulators X, Y and Z.
// RL6 - Moves, swaps, arithmetic and shifts take any of four accumulators.
// RL7 - Not-equal and sign flags update on every destination write; the swap source write and the measurement-end preset of X, Y and Z leave them unchanged.
// RL8 - Carry and overflow also update on add, subtract and shifts.
// RL9 - Each flag is selectable for a conditional jump or skip.
// RL10 - Carry holds add carry, subtract borrow, or shifted-out bit.
// RL11 - Not-equal flag goes to zero when a nonzero result is written.
// RL12 - Sign flag set when written result has its top bit one.
// RL13 - Overflow flags two's complement overflow of add or subtract.
// RL14 - Measurement end fills words 16 to 20 with bridge results.
// RL15 - Words 21 to 25 get temperature, status, time, resolution, supply.
// RL16 - Words 26 to 28 get io edges and level, 29 the timer.
// RL17 - Words 30 and 31 are overwritten by each measurement.
// RL18 - At end X, Y, Z load sum, temperature, word 63; pointer zero.
// RL19 - Bridge results come scaled in hundredths of a ppm.
// RL20 - Bridge and temperature results are 24-bit two's complement.
// RL21 - Status bit 19 marks a power-on reset entry.
// RL22 - Flags change in the same cycle as the result write.
// RL23 - Arithmetic wraps modulo two to the twenty-fourth.
`timescale 1ns/1ps

module afr_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Instruction from the sequencer
    input wire logic instr_valid,
    input afr_pkg::afr_instr_t instr,
    input afr_pkg::afr_ptr_cmd_t ptr_cmd,
    input afr_pkg::afr_flag_sel_t test_sel,
    // Converter end of measurement
    input wire logic meas_done,
    input wire logic por_entry,
    input afr_pkg::afr_result_t meas,
    // Program access to RAM words
    input wire logic [6:0] ram_rd_addr,
    output logic [23:0] ram_rd_data,
    // Accumulators and flags
    output logic [23:0] acc_x,
    output logic [23:0] acc_y,
    output logic [23:0] acc_z,
    output logic [23:0] acc_r,
    output logic [6:0] ram_ptr,
    output afr_pkg::afr_flags_t flags,
    output logic test_flag
);

    // ********
    // Storage
    // ********
    // RL1 - word array
    logic [23:0] ram_q [afr_pkg::RAM_WORDS];
    logic [23:0] x_q;
    logic [23:0] y_q;
    logic [23:0] z_q;
    logic [6:0] ptr_q;
    afr_pkg::afr_flags_t flags_q;
    logic [23:0] rd_q;

    // ********
    // Operand fetch and result
    // ********
    logic [23:0] mapped;
    logic [23:0] opa;
    logic [23:0] opb;
    logic [23:0] res_d;
    logic [23:0] swap_d;
    logic carry_d;
    logic ovf_d;
    logic calc_d;
    logic wr_dst;
    logic wr_src;
    logic [24:0] sum;

    // Out-of-range pointer reads as zero rather than X
    // RL2 - mapped word
    assign mapped = (ptr_q < 7'(afr_pkg::RAM_WORDS)) ? ram_q[ptr_q]
                                                     : 24'h000000;

    // Operand multiplexer over all four accumulators
    function automatic logic [23:0] pick(input afr_pkg::afr_acc_t a,
                                         input logic [23:0] x,
                                         input logic [23:0] y,
                                         input logic [23:0] z,
                                         input logic [23:0] r);
        case (a)
            afr_pkg::AFR_ACC_X: pick = x;
            afr_pkg::AFR_ACC_Y: pick = y;
            afr_pkg::AFR_ACC_Z: pick = z;
            default: pick = r;
        endcase
    endfunction

    // RL6 - any accumulator
    assign opa = pick(instr.dst, x_q, y_q, z_q, mapped);
    assign opb = instr.use_imm ? instr.imm
                               : pick(instr.src, x_q, y_q, z_q, mapped);

    // ALU; all results truncate to the word width
    always_comb begin
        sum = 25'h0;
        res_d = opa;
        swap_d = opb;
        carry_d = flags_q.carry;
        ovf_d = flags_q.overflow;
        calc_d = 1'b0;
        wr_dst = 1'b0;
        wr_src = 1'b0;
        if (instr_valid) begin
            case (instr.op)
                afr_pkg::AFR_OP_MOVE, afr_pkg::AFR_OP_LOAD_IMM: begin
                    res_d = opb;
                    wr_dst = 1'b1;
                end
                afr_pkg::AFR_OP_SWAP: begin
                    res_d = opb;
                    swap_d = opa;
                    wr_dst = 1'b1;
                    wr_src = ~instr.use_imm;
                end
                // RL23 - wrap sum
                afr_pkg::AFR_OP_ADD: begin
                    sum = {1'b0, opa} + {1'b0, opb};
                    res_d = sum[23:0];
                    // RL10 - add carry
                    carry_d = sum[24];
                    // RL13 - add overflow
                    ovf_d = (opa[23] == opb[23]) && (res_d[23] != opa[23]);
                    calc_d = 1'b1;
                    wr_dst = 1'b1;
                end
                afr_pkg::AFR_OP_SUB: begin
                    sum = {1'b0, opa} - {1'b0, opb};
                    res_d = sum[23:0];
                    // RL10 - borrow out
                    carry_d = sum[24];
                    // RL13 - sub overflow
                    ovf_d = (opa[23] != opb[23]) && (res_d[23] != opa[23]);
                    calc_d = 1'b1;
                    wr_dst = 1'b1;
                end
                afr_pkg::AFR_OP_SHIFT_LEFT: begin
                    res_d = {opa[22:0], 1'b0};
                    carry_d = opa[23];
                    ovf_d = opa[23] ^ opa[22];
                    calc_d = 1'b1;
                    wr_dst = 1'b1;
                end
                // RL10 - shifted-out bit
                afr_pkg::AFR_OP_SHIFT_RIGHT: begin
                    res_d = {opa[23], opa[23:1]};
                    carry_d = opa[0];
                    ovf_d = 1'b0;
                    calc_d = 1'b1;
                    wr_dst = 1'b1;
                end
                afr_pkg::AFR_OP_ROTATE_RIGHT: begin
                    res_d = {flags_q.carry, opa[23:1]};
                    carry_d = opa[0];
                    calc_d = 1'b1;
                    wr_dst = 1'b1;
                end
                afr_pkg::AFR_OP_ROTATE_LEFT: begin
                    res_d = {opa[22:0], flags_q.carry};
                    carry_d = opa[23];
                    calc_d = 1'b1;
                    wr_dst = 1'b1;
                end
                default: begin
                    res_d = opa;
                end
            endcase
        end
    end

    // ********
    // Accumulator registers
    // ********
    // RL5 - X Y Z registers; measurement end takes priority
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            x_q <= 24'h000000;
            y_q <= 24'h000000;
            z_q <= 24'h000000;
        end else if (meas_done) begin
            // RL18 - preset accumulators
            x_q <= meas.bridge_sum;
            y_q <= meas.temperature;
            z_q <= ram_q[afr_pkg::Z_PRESET_WORD];
        end else begin
            if (wr_dst && instr.dst == afr_pkg::AFR_ACC_X) begin
                x_q <= res_d;
            end else if (wr_src && instr.src == afr_pkg::AFR_ACC_X) begin
                x_q <= swap_d;
            end
            if (wr_dst && instr.dst == afr_pkg::AFR_ACC_Y) begin
                y_q <= res_d;
            end else if (wr_src && instr.src == afr_pkg::AFR_ACC_Y) begin
                y_q <= swap_d;
            end
            if (wr_dst && instr.dst == afr_pkg::AFR_ACC_Z) begin
                z_q <= res_d;
            end else if (wr_src && instr.src == afr_pkg::AFR_ACC_Z) begin
                z_q <= swap_d;
            end
        end
    end

    // ********
    // RAM array and result map
    // ********
    // One generate entry per word; results and mapped writes share it
    genvar gi;
    generate
        for (gi = 0; gi < afr_pkg::RAM_WORDS; gi++) begin : g_word
            logic [23:0] res_word;
            logic in_map;
            // Slot clamped so words off the map never select past the bundle
            localparam int SLOT = ((gi >= afr_pkg::RESULT_FIRST) &&
                (gi < afr_pkg::RESULT_FIRST + afr_pkg::RESULT_COUNT)) ?
                gi - afr_pkg::RESULT_FIRST : 0;
            assign in_map = (gi >= afr_pkg::RESULT_FIRST) &&
                (gi < afr_pkg::RESULT_FIRST + afr_pkg::RESULT_COUNT);
            // RL14 - result word order follows the struct, word 16 first
            // RL19 - scaling comes from the converter unchanged
            // RL20 - signed words stored as delivered
            always_comb begin
                res_word = 24'h000000;
                if (in_map) begin
                    res_word = meas[(afr_pkg::RESULT_COUNT - 1 - SLOT) * 24
                        +: 24];
                end
                // RL21 - power-on entry bit
                if (gi == afr_pkg::STATUS_WORD) begin
                    res_word[afr_pkg::STATUS_POR_BIT] = por_entry;
                end
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    ram_q[gi] <= 24'h000000;
                end else if (meas_done && in_map) begin
                    // RL15 - status and converter words
                    // RL16 - io and timer words
                    // RL17 - scratch words overwritten
                    ram_q[gi] <= res_word;
                end else if (ptr_q == 7'(gi) && ((wr_dst &&
                    instr.dst == afr_pkg::AFR_ACC_R) || (wr_src &&
                    instr.src == afr_pkg::AFR_ACC_R))) begin
                    // RL2 - mapped word as destination
                    ram_q[gi] <= (wr_dst && instr.dst == afr_pkg::AFR_ACC_R)
                        ? res_d : swap_d;
                end
            end
        end
    endgenerate

    // ********
    // RAM address pointer
    // ********
    // RL4 - pointer commands and measurement end only
    // RL3 - pointer moves touch no RAM word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ptr_q <= afr_pkg::PTR_RESET;
        end else if (meas_done) begin
            // RL18 - pointer cleared
            ptr_q <= afr_pkg::PTR_RESET;
        end else begin
            case (ptr_cmd.op)
                afr_pkg::AFR_PTR_LOAD: ptr_q <= ptr_cmd.addr;
                afr_pkg::AFR_PTR_INC: ptr_q <= ptr_q + 7'h01;
                afr_pkg::AFR_PTR_DEC: ptr_q <= ptr_q - 7'h01;
                default: ptr_q <= ptr_q;
            endcase
        end
    end

    // ********
    // Flags
    // ********
    // RL22 - same-cycle flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_q <= afr_pkg::FLAGS_RESET;
        end else if (wr_dst) begin
            // RL7 - written-result flags
            // RL11 - zero when result nonzero, as the device defines it
            flags_q.not_equal <= (res_d == 24'h000000);
            // RL12 - sign from top bit
            flags_q.sign <= res_d[23];
            // RL8 - calc flags
            if (calc_d) begin
                flags_q.carry <= carry_d;
                flags_q.overflow <= ovf_d;
            end
        end
    end

    // ********
    // Outputs, all registered
    // ********
    // Read port is a plain registered read of the array
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_q <= 24'h000000;
        end else if (ram_rd_addr < 7'(afr_pkg::RAM_WORDS)) begin
            rd_q <= ram_q[ram_rd_addr];
        end else begin
            rd_q <= 24'h000000;
        end
    end

    // Mapped word mirrored into a register for the output
    logic [23:0] r_q;
    logic test_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_q <= 24'h000000;
        end else begin
            r_q <= mapped;
        end
    end

    // RL9 - flag selector for jumps, registered one cycle behind the flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            test_q <= 1'b0;
        end else begin
            case (test_sel)
                afr_pkg::AFR_FLG_CARRY: test_q <= flags_q.carry;
                afr_pkg::AFR_FLG_NOT_EQUAL: test_q <= flags_q.not_equal;
                afr_pkg::AFR_FLG_SIGN: test_q <= flags_q.sign;
                default: test_q <= flags_q.overflow;
            endcase
        end
    end

    assign acc_x = x_q;
    assign acc_y = y_q;
    assign acc_z = z_q;
    assign acc_r = r_q;
    assign ram_ptr = ptr_q;
    assign flags = flags_q;
    assign test_flag = test_q;
    assign ram_rd_data = rd_q;

endmodule

//--- verilog/afr_pkg.sv
// Package for the accumulator, flag and result map datapath.
// Assumes one processor clock shared by sequencer and converter.
package afr_pkg;

    // ********
    // Widths and sizes
    // ********
    localparam int WORD_W = 24;
    localparam int ADDR_W = 7;
    localparam int RAM_WORDS = 127;

    // ********
    // Result map word addresses
    // ********
    localparam logic [6:0] BRIDGE_ONE_RATIO = 7'h10;
    localparam logic [6:0] BRIDGE_TWO_RATIO = 7'h11;
    localparam logic [6:0] BRIDGE_THREE_RATIO = 7'h12;
    localparam logic [6:0] BRIDGE_FOUR_RATIO = 7'h13;
    localparam logic [6:0] COMPENSATED_BRIDGE_SUM = 7'h14;
    localparam logic [6:0] TEMPERATURE_RATIO = 7'h15;
    localparam logic [6:0] STATUS_WORD = 7'h16;
    localparam logic [6:0] FIRST_PORT_DISCHARGE_TIME = 7'h17;
    localparam logic [6:0] TIME_CONVERTER_RESOLUTION = 7'h18;
    localparam logic [6:0] SUPPLY_VOLTAGE_RESULT = 7'h19;
    localparam logic [6:0] IO_FALLING_EDGES = 7'h1a;
    localparam logic [6:0] IO_RISING_EDGES = 7'h1b;
    localparam logic [6:0] IO_HELD_HIGH = 7'h1c;
    localparam logic [6:0] TIMER_VALUE = 7'h1d;
    localparam logic [6:0] SCRATCH_A = 7'h1e;
    localparam logic [6:0] SCRATCH_B = 7'h1f;
    localparam logic [6:0] Z_PRESET_WORD = 7'h3f;
    localparam logic [6:0] PTR_RESET = 7'h00;
    localparam int RESULT_FIRST = 16;
    localparam int RESULT_COUNT = 16;
    localparam int STATUS_POR_BIT = 19;

    // ********
    // Accumulator select and operations
    // ********
    typedef enum logic [1:0] {
        AFR_ACC_X,
        AFR_ACC_Y,
        AFR_ACC_Z,
        AFR_ACC_R
    } afr_acc_t;

    typedef enum logic [3:0] {
        AFR_OP_NONE,
        AFR_OP_MOVE,
        AFR_OP_SWAP,
        AFR_OP_ADD,
        AFR_OP_SUB,
        AFR_OP_SHIFT_LEFT,
        AFR_OP_SHIFT_RIGHT,
        AFR_OP_ROTATE_RIGHT,
        AFR_OP_ROTATE_LEFT,
        AFR_OP_LOAD_IMM
    } afr_op_t;

    typedef enum logic [1:0] {
        AFR_PTR_HOLD,
        AFR_PTR_LOAD,
        AFR_PTR_INC,
        AFR_PTR_DEC
    } afr_ptr_op_t;

    typedef enum logic [1:0] {
        AFR_FLG_CARRY,
        AFR_FLG_NOT_EQUAL,
        AFR_FLG_SIGN,
        AFR_FLG_OVERFLOW
    } afr_flag_sel_t;

    // Instruction from the sequencer
    typedef struct packed {
        afr_op_t op;
        afr_acc_t dst;
        afr_acc_t src;
        logic use_imm;
        logic [23:0] imm;
    } afr_instr_t;

    // Pointer command
    typedef struct packed {
        afr_ptr_op_t op;
        logic [6:0] addr;
    } afr_ptr_cmd_t;

    // Converter end-of-measurement bundle
    typedef struct packed {
        logic [23:0] bridge_one;
        logic [23:0] bridge_two;
        logic [23:0] bridge_three;
        logic [23:0] bridge_four;
        logic [23:0] bridge_sum;
        logic [23:0] temperature;
        logic [23:0] status;
        logic [23:0] discharge;
        logic [23:0] resolution;
        logic [23:0] supply;
        logic [23:0] io_fall;
        logic [23:0] io_rise;
        logic [23:0] io_high;
        logic [23:0] timer;
        logic [23:0] scratch_a;
        logic [23:0] scratch_b;
    } afr_result_t;

    // Condition flags
    typedef struct packed {
        logic carry;
        logic not_equal;
        logic sign;
        logic overflow;
    } afr_flags_t;

    localparam afr_flags_t FLAGS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage

//--- verification/afr_core_properties.sv
// Concurrent checks on the ports of the datapath core.
// Assumes it is bound onto afr_core, one clock, sync active high reset.
`timescale 1ns/1ps

module afr_core_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Sequencer and converter side
    input wire logic instr_valid,
    input afr_pkg::afr_instr_t instr,
    input afr_pkg::afr_ptr_cmd_t ptr_cmd,
    input afr_pkg::afr_flag_sel_t test_sel,
    input wire logic meas_done,
    input afr_pkg::afr_result_t meas,
    // Datapath state
    input logic [23:0] acc_x,
    input logic [23:0] acc_y,
    input logic [23:0] acc_z,
    input logic [6:0] ram_ptr,
    input afr_pkg::afr_flags_t flags,
    input logic test_flag
);
    logic add_xy;
    logic sel_bit;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ********
    // Helper terms
    // ********
    // Plain Y into X addition, the only case the carry model covers
    assign add_xy = instr_valid && !meas_done && !instr.use_imm
        && instr.op == afr_pkg::AFR_OP_ADD
        && instr.dst == afr_pkg::AFR_ACC_X
        && instr.src == afr_pkg::AFR_ACC_Y;
    // Flag struct is carry first, so the select counts from the top
    assign sel_bit = flags[2'd3 - test_sel];

    // ********
    // Assertions
    // ********
    // pointer holds
    ptr_hold_a: assert property (
        ptr_cmd.op == afr_pkg::AFR_PTR_HOLD && !meas_done
        |=> $stable(ram_ptr)) else $error("pointer moved unasked");
    ptr_inc_a: assert property (
        ptr_cmd.op == afr_pkg::AFR_PTR_INC && !meas_done
        && ram_ptr < 7'h7d |=> ram_ptr == $past(ram_ptr) + 7'h01)
        else $error("pointer increment wrong");
    ptr_load_a: assert property (
        ptr_cmd.op == afr_pkg::AFR_PTR_LOAD && !meas_done
        && ptr_cmd.addr < 7'h7f |=> ram_ptr == $past(ptr_cmd.addr))
        else $error("pointer load wrong");
    meas_preset_a: assert property (
        meas_done |=> acc_x == $past(meas.bridge_sum)
        && acc_y == $past(meas.temperature) && ram_ptr == 7'h00)
        else $error("measurement preset wrong");
    test_flag_a: assert property (
        !$past(rst) |-> test_flag == $past(sel_bit))
        else $error("tested flag differs from selected flag");
    write_flags_a: assert property (
        instr_valid && !meas_done && instr.dst == afr_pkg::AFR_ACC_X
        && instr.op inside {afr_pkg::AFR_OP_MOVE, afr_pkg::AFR_OP_ADD,
        afr_pkg::AFR_OP_SUB} |=> flags.sign == acc_x[23]
        && flags.not_equal == (acc_x == 24'h000000))
        else $error("sign or zero flag wrong after write");
    add_carry_a: assert property (
        add_xy |=> {flags.carry, acc_x}
        == {1'b0, $past(acc_x)} + {1'b0, $past(acc_y)})
        else $error("add sum or carry wrong");
    add_ovf_a: assert property (
        add_xy |=> flags.overflow == ($past(acc_x[23]) == $past(acc_y[23])
        && acc_x[23] != $past(acc_x[23])))
        else $error("add overflow wrong");
    move_cv_a: assert property (
        instr_valid && !meas_done && instr.op == afr_pkg::AFR_OP_MOVE
        |=> $stable(flags.carry) && $stable(flags.overflow))
        else $error("move changed carry or overflow");
    acc_hold_a: assert property (
        !instr_valid && !meas_done
        |=> $stable(acc_x) && $stable(acc_y) && $stable(acc_z))
        else $error("accumulator changed while idle");
endmodule

bind afr_core afr_core_properties u_props (.ref_clk, .rst, .instr_valid,
    .instr, .ptr_cmd, .test_sel, .meas_done, .meas, .acc_x, .acc_y,
    .acc_z, .ram_ptr, .flags, .test_flag);

//--- verification/afr_conv_model.sv
// Converter front end stand-in: hands over one result bundle per call.
// Assumes the bench calls finish() from its main sequence.
`timescale 1ns/1ps

module afr_conv_model (
    // Clock
    input wire logic ref_clk,
    // End of measurement towards the core
    output logic meas_done,
    output logic por_entry,
    output afr_pkg::afr_result_t meas
);
    initial begin
        meas_done = 1'b0;
        por_entry = 1'b0;
        meas = '0;
    end

    task automatic finish(input logic por);
        @(posedge ref_clk);
        for (int i = 0; i < 16; i++) begin
            meas[383 - 24 * i -: 24] <= 24'h800000 + 24'(i) * 24'h010101;
        end
        por_entry <= por;
        meas_done <= 1'b1;
        @(posedge ref_clk);
        // Bundle no longer valid: show inverted data, never stale data
        meas_done <= 1'b0;
        por_entry <= ~por;
        meas <= ~meas;
    endtask
endmodule

//--- verification/afr_core_tb.sv
// Self-checking bench for the accumulator, flag and result map core.
// Assumes afr_core, its bound checker and the converter model.
`timescale 1ns/1ps

module afr_core_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    afr_pkg::afr_instr_t instr = '0;
    afr_pkg::afr_ptr_cmd_t ptr_cmd = '0;
    afr_pkg::afr_flag_sel_t test_sel = afr_pkg::AFR_FLG_CARRY;
    logic [6:0] ram_rd_addr = 7'h00;
    logic [23:0] ram_rd_data, acc_x, acc_y, acc_z, acc_r;
    logic [6:0] ram_ptr;
    afr_pkg::afr_flags_t flags;
    logic test_flag, meas_done, por_entry;
    afr_pkg::afr_result_t meas;
    int n_errors = 0;
    int checks_done = 0;
    localparam afr_pkg::afr_acc_t ax = afr_pkg::AFR_ACC_X;
    localparam afr_pkg::afr_acc_t ay = afr_pkg::AFR_ACC_Y;
    localparam afr_pkg::afr_acc_t az = afr_pkg::AFR_ACC_Z;

    // 100 MHz processor clock
    always #5 ref_clk = ~ref_clk;

    afr_core dut (.ref_clk, .rst, .instr_valid, .instr, .ptr_cmd,
        .test_sel, .meas_done, .por_entry, .meas, .ram_rd_addr,
        .ram_rd_data, .acc_x, .acc_y, .acc_z, .acc_r, .ram_ptr, .flags,
        .test_flag);

    afr_conv_model conv (.ref_clk, .meas_done, .por_entry, .meas);

    // ********
    // Report, compare and drive tasks
    // ********
    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [23:0] exp,
        input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flags(input string what, input logic [3:0] exp);
        checks_done++;
        if (flags !== exp) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, flags);
        end
    endtask

    // One instruction, held for exactly the edge that takes it
    task automatic op(input afr_pkg::afr_op_t o, input afr_pkg::afr_acc_t d,
        input afr_pkg::afr_acc_t s, input logic [23:0] imm, input logic ui);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr <= '{o, d, s, ui, imm};
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic ld(input afr_pkg::afr_acc_t d, input logic [23:0] v);
        op(afr_pkg::AFR_OP_MOVE, d, afr_pkg::AFR_ACC_X, v, 1'b1);
    endtask

    task automatic ptr(input afr_pkg::afr_ptr_op_t o, input logic [6:0] a);
        @(posedge ref_clk);
        ptr_cmd <= '{o, a};
        @(posedge ref_clk);
        ptr_cmd <= '{afr_pkg::AFR_PTR_HOLD, 7'h00};
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [6:0] a, output logic [23:0] d);
        @(posedge ref_clk);
        ram_rd_addr <= a;
        @(posedge ref_clk);
        #1;
        d = ram_rd_data;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        logic [23:0] d;
        @(posedge ref_clk);
        #1;
        chk_word("acc_x reset", 24'h000000, acc_x);
        chk_word("acc_z reset", 24'h000000, acc_z);
        chk_flags("reset flags", 4'b0000);
        rd(7'h10, d);
        chk_word("ram reset", 24'h000000, d);
    endtask

    // Signed overflow, every flag through the select, then wrap to zero
    task automatic t_add();
        ld(ax, 24'h7fffff);
        ld(ay, 24'h000001);
        op(afr_pkg::AFR_OP_ADD, ax, ay, 0, 0);
        chk_word("add sum", 24'h800000, acc_x);
        chk_flags("add ovf flags", 4'b0011);
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk);
            test_sel <= afr_pkg::afr_flag_sel_t'(s);
            @(posedge ref_clk);
            #1;
            chk_word("test flag", s > 1 ? 24'h1 : 24'h0, 24'(test_flag));
        end
        ld(ax, 24'hffffff);
        op(afr_pkg::AFR_OP_ADD, ax, ay, 0, 0);
        chk_word("wrap sum", 24'h000000, acc_x);
        chk_flags("wrap flags", 4'b1100);
        chk_word("ptr after add", 24'h0, 24'(ram_ptr));
    endtask

    // Borrow, move keeping carry, subtract overflow
    task automatic t_sub();
        op(afr_pkg::AFR_OP_SUB, ax, ay, 0, 0);
        chk_word("sub diff", 24'hffffff, acc_x);
        chk_flags("borrow flags", 4'b1010);
        ld(ax, 24'h000005);
        chk_flags("move flags", 4'b1000);
        ld(ax, 24'h800000);
        op(afr_pkg::AFR_OP_SUB, ax, ay, 0, 0);
        chk_word("sub ovf diff", 24'h7fffff, acc_x);
        chk_flags("sub ovf flags", 4'b0001);
    endtask

    // Bit shifted out lands in carry; swap exchanges two accumulators
    task automatic t_shift();
        ld(az, 24'h000003);
        op(afr_pkg::AFR_OP_SHIFT_RIGHT, az, az, 0, 0);
        chk_word("shift right", 24'h000001, acc_z);
        chk_flags("shift right flags", 4'b1000);
        ld(az, 24'h800001);
        op(afr_pkg::AFR_OP_SHIFT_LEFT, az, az, 0, 0);
        chk_word("shift left", 24'h000002, acc_z);
        chk_word("shift out", 24'h1, 24'(flags.carry));
        // Rotates pass through carry: right takes it in, left gives it back
        op(afr_pkg::AFR_OP_ROTATE_RIGHT, az, az, 0, 0);
        chk_word("rotate right", 24'h800001, acc_z);
        op(afr_pkg::AFR_OP_ROTATE_LEFT, az, az, 0, 0);
        chk_word("rotate left", 24'h000002, acc_z);
        op(afr_pkg::AFR_OP_SWAP, ax, az, 0, 0);
        chk_word("swap x", 24'h000002, acc_x);
        chk_word("swap z", 24'h7fffff, acc_z);
    endtask

    // Mapped word as operand and destination; pointer moves keep RAM
    task automatic t_ram();
        logic [23:0] d;
        ptr(afr_pkg::AFR_PTR_LOAD, 7'h05);
        ld(afr_pkg::AFR_ACC_R, 24'h123456);
        @(posedge ref_clk);
        #1;
        chk_word("mapped word", 24'h123456, acc_r);
        op(afr_pkg::AFR_OP_ADD, afr_pkg::AFR_ACC_X, afr_pkg::AFR_ACC_R, 0, 0);
        chk_word("add mapped", 24'h123458, acc_x);
        chk_word("ptr kept", 24'h5, 24'(ram_ptr));
        ptr(afr_pkg::AFR_PTR_INC, 7'h00);
        chk_word("ptr inc", 24'h6, 24'(ram_ptr));
        chk_word("next word", 24'h000000, acc_r);
        ptr(afr_pkg::AFR_PTR_DEC, 7'h00);
        chk_word("word kept", 24'h123456, acc_r);
        rd(7'h05, d);
        chk_word("ram read", 24'h123456, d);
        ptr(afr_pkg::AFR_PTR_LOAD, 7'h7e);
        ld(afr_pkg::AFR_ACC_R, 24'h00c0de);
        rd(7'h7e, d);
        chk_word("top word", 24'h00c0de, d);
        ptr(afr_pkg::AFR_PTR_LOAD, 7'h3f);
        ld(afr_pkg::AFR_ACC_R, 24'habcdef);
        ptr(afr_pkg::AFR_PTR_LOAD, 7'h28);
    endtask

    // End of measurement fills the result map and presets accumulators
    task automatic t_meas(input logic por);
        logic [23:0] d;
        logic [23:0] e;
        conv.finish(por);
        #1;
        chk_word("x preset", 24'h840404, acc_x);
        chk_word("y preset", 24'h850505, acc_y);
        chk_word("z preset", 24'habcdef, acc_z);
        chk_word("ptr preset", 24'h0, 24'(ram_ptr));
        for (int i = 0; i < 16; i++) begin
            e = 24'h800000 + 24'(i) * 24'h010101;
            if (i == 6) begin
                e[19] = por;
            end
            rd(7'(16 + i), d);
            chk_word("result word", e, d);
        end
    endtask

    // ********
    // Main sequence and watchdog
    // ********
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_add();
        t_sub();
        t_shift();
        t_ram();
        t_meas(1'b1);
        t_meas(1'b0);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end
endmodule
